// file: core/itl_launch.sv
// itl_launch: transaction request register, launch and reject logic
// assumes: synchronous register port, bus engine reports end of transaction
// How it works
// - a write to the request register while idle launches a transaction
// - one transaction at a time; writes while active are dropped, register kept
// - a dropped write pulses the request rejected fault
// - reading the request register returns the last accepted request
// - bit 15 picks first or second pointer byte
// - in two-byte pointer mode both pointer bytes go out, bit 15 ignored
// - bits 14:13 give 1, 2, 3 or 4 data bytes, default two
// - alternate write mode turns length code 10 into zero bytes on writes
// - bits 12:11 select data byte location 0 to 3, default 1
// - location is the top byte; length counts bytes down from it
// - bits 10:8 are target address bits 9:7 in ten-bit mode
// - seven-bit mode forces the upper address bits to zero
// - bits 7:1 are target address bits 6:0
// - bit 0 sets direction, 0 write, 1 read
`timescale 1ns/1ns
`default_nettype none
module itl_launch (
  // clock, reset, enable
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  // register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output var  logic [15:0] reg_rdata_o,
  // configuration levels
  input  wire logic        pointer_length_mode_i,
  input  wire logic        alternate_write_mode_i,
  input  wire logic        ten_bit_mode_i,
  // bus engine status
  input  wire logic        txn_end_i,
  // launch and status
  output var  logic        launch_o,
  output var  logic        active_o,
  output var  logic        request_rejected_fault_o,
  // decoded transaction
  output var  logic [9:0]  target_address_o,
  output var  logic        ten_bit_o,
  output var  logic        read_not_write_o,
  output var  logic        send_pointer_byte_first_o,
  output var  logic        send_pointer_byte_second_o,
  output var  logic [2:0]  data_byte_count_o,
  output var  logic [1:0]  data_location_select_o,
  output var  logic [3:0]  data_byte_enable_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    itl_pkg::itl_state_type state;
    logic [15:0]            req;
    logic [15:0]            rdata;
    logic                   launch;
    logic                   rej;
    logic [9:0]             tgt;
    logic                   ten;
    logic                   rnw;
    logic                   pfirst;
    logic                   psecond;
    logic [2:0]             cnt;
    logic [1:0]             loc;
    logic [3:0]             ben;
  } itl_regs_type;

  itl_regs_type r_q;
  itl_regs_type r_d;

  logic         wr_hit;
  logic         rd_hit;
  logic [15:0]  w;
  logic [1:0]   w_len;
  logic [1:0]   w_loc;

  assign wr_hit = reg_wr_i && (reg_addr_i == itl_pkg::REQ_ADDR);
  assign rd_hit = reg_rd_i && (reg_addr_i == itl_pkg::REQ_ADDR);
  assign w      = reg_wdata_i;
  assign w_len  = w[itl_pkg::LEN_MSB:itl_pkg::LEN_LSB];
  assign w_loc  = w[itl_pkg::LOC_MSB:itl_pkg::LOC_LSB];

  // ----------------------------------------------------------------
  // byte enables: from location downward, count bytes
  // ----------------------------------------------------------------
  function automatic logic [3:0] byte_mask(input logic [1:0] loc, input logic [2:0] cnt);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if ((i <= int'(loc)) && ((int'(loc) - i) < int'(cnt))) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : byte_mask

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d        = r_q;
    r_d.launch = 1'b0;
    r_d.rej    = 1'b0;
    r_d.rdata  = rd_hit ? r_q.req : 16'h0000;
    case (r_q.state)
      itl_pkg::ITL_IDLE: begin
        if (wr_hit) begin
          r_d.state  = itl_pkg::ITL_ACTIVE;
          r_d.launch = 1'b1;
          r_d.req    = w;
          r_d.rnw    = w[itl_pkg::RNW_BIT];
          r_d.ten    = ten_bit_mode_i;
          r_d.tgt[6:0] = w[itl_pkg::ADDR_LO_MSB:itl_pkg::ADDR_LO_LSB];
          r_d.tgt[9:7] = ten_bit_mode_i ? w[itl_pkg::ADDR_HI_MSB:itl_pkg::ADDR_HI_LSB]
                                        : 3'h0;
          r_d.pfirst  = pointer_length_mode_i || !w[itl_pkg::PSEL_BIT];
          r_d.psecond = pointer_length_mode_i || w[itl_pkg::PSEL_BIT];
          r_d.loc     = w_loc;
          case (w_len)
            itl_pkg::LEN_ONE: r_d.cnt = itl_pkg::CNT_ONE;
            itl_pkg::LEN_TWO: r_d.cnt = itl_pkg::CNT_TWO;
            itl_pkg::LEN_THREE: begin
              r_d.cnt = (alternate_write_mode_i && !w[itl_pkg::RNW_BIT]) ?
                        itl_pkg::CNT_ZERO : itl_pkg::CNT_THREE;
            end
            default: r_d.cnt = itl_pkg::CNT_FOUR;
          endcase
          r_d.ben = byte_mask(w_loc, r_d.cnt);
        end
      end
      itl_pkg::ITL_ACTIVE: begin
        if (wr_hit) begin
          r_d.rej = 1'b1;
        end
        if (txn_end_i) begin
          r_d.state = itl_pkg::ITL_IDLE;
        end
      end
      default: r_d.state = itl_pkg::ITL_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_q         <= '0;
      r_q.state   <= itl_pkg::ITL_IDLE;
      r_q.req     <= itl_pkg::REQ_RESET;
      r_q.pfirst  <= 1'b1;
      r_q.cnt     <= itl_pkg::CNT_TWO;
      r_q.loc     <= itl_pkg::REQ_RESET[itl_pkg::LOC_MSB:itl_pkg::LOC_LSB];
      r_q.ben     <= 4'h3;
    end else if (ce_i) begin
      r_q <= r_d;
    end
  end

  assign reg_rdata_o                = r_q.rdata;
  assign launch_o                   = r_q.launch;
  assign active_o                   = (r_q.state == itl_pkg::ITL_ACTIVE);
  assign request_rejected_fault_o   = r_q.rej;
  assign target_address_o           = r_q.tgt;
  assign ten_bit_o                  = r_q.ten;
  assign read_not_write_o           = r_q.rnw;
  assign send_pointer_byte_first_o  = r_q.pfirst;
  assign send_pointer_byte_second_o = r_q.psecond;
  assign data_byte_count_o          = r_q.cnt;
  assign data_location_select_o     = r_q.loc;
  assign data_byte_enable_o         = r_q.ben;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_idle_write;
    ce_i && wr_hit && !active_o;
  endsequence
  sequence s_busy_write;
    ce_i && wr_hit && active_o;
  endsequence

  property p_launch;
    s_idle_write |=> launch_o && active_o && !request_rejected_fault_o &&
                     (r_q.req == $past(reg_wdata_i));
  endproperty
  a_launch: assert property (p_launch) else $error("idle write did not launch");

  property p_keep;
    s_busy_write |=> !launch_o && $stable(r_q.req);
  endproperty
  a_keep: assert property (p_keep) else $error("busy write changed request");

  property p_reject;
    s_busy_write |=> request_rejected_fault_o;
  endproperty
  a_reject: assert property (p_reject) else $error("busy write not rejected");

  property p_no_false_reject;
    request_rejected_fault_o && $past(ce_i) |-> $past(active_o) && $past(wr_hit);
  endproperty
  a_no_false_reject: assert property (p_no_false_reject) else $error("spurious reject");

  property p_readback;
    ce_i && rd_hit |=> reg_rdata_o == $past(r_q.req);
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  property p_pointer;
    launch_o |-> (send_pointer_byte_second_o == ($past(pointer_length_mode_i) ||
                  r_q.req[itl_pkg::PSEL_BIT]));
  endproperty
  a_pointer: assert property (p_pointer) else $error("pointer choice wrong");

  property p_alt_zero;
    s_idle_write ##0 (w_len == itl_pkg::LEN_THREE) ##0 alternate_write_mode_i ##0
      !w[itl_pkg::RNW_BIT] |=> data_byte_count_o == itl_pkg::CNT_ZERO;
  endproperty
  a_alt_zero: assert property (p_alt_zero) else $error("alt write length wrong");

  property p_addr7;
    launch_o && !ten_bit_o |-> target_address_o[9:7] == 3'h0 &&
      target_address_o[6:0] == r_q.req[itl_pkg::ADDR_LO_MSB:itl_pkg::ADDR_LO_LSB];
  endproperty
  a_addr7: assert property (p_addr7) else $error("seven-bit address wrong");

  property p_dir;
    launch_o |-> read_not_write_o == r_q.req[itl_pkg::RNW_BIT];
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");

  property p_end;
    ce_i && active_o && txn_end_i |=> !active_o;
  endproperty
  a_end: assert property (p_end) else $error("active did not end");

endmodule : itl_launch
`default_nettype wire

// file: core/itl_pkg.sv
// itl_pkg: constants and types for the transaction request and launch block
// assumes: a 16-bit register port with an 8-bit register index
package itl_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  REQ_ADDR      = 8'h8B;
  localparam logic [15:0] REQ_RESET     = 16'h2800;
  localparam int          REG_W         = 16;
  localparam int          ADDR_W        = 8;

  // ----------------------------------------------------------------
  // request field positions
  // ----------------------------------------------------------------
  localparam int          RNW_BIT       = 0;
  localparam int          ADDR_LO_LSB   = 1;
  localparam int          ADDR_LO_MSB   = 7;
  localparam int          ADDR_HI_LSB   = 8;
  localparam int          ADDR_HI_MSB   = 10;
  localparam int          LOC_LSB       = 11;
  localparam int          LOC_MSB       = 12;
  localparam int          LEN_LSB       = 13;
  localparam int          LEN_MSB       = 14;
  localparam int          PSEL_BIT      = 15;

  // ----------------------------------------------------------------
  // data length codes and byte counts
  // ----------------------------------------------------------------
  localparam logic [1:0]  LEN_ONE       = 2'h0;
  localparam logic [1:0]  LEN_TWO       = 2'h1;
  localparam logic [1:0]  LEN_THREE     = 2'h2;
  localparam logic [1:0]  LEN_FOUR      = 2'h3;
  localparam logic [2:0]  CNT_ZERO      = 3'h0;
  localparam logic [2:0]  CNT_ONE       = 3'h1;
  localparam logic [2:0]  CNT_TWO       = 3'h2;
  localparam logic [2:0]  CNT_THREE     = 3'h3;
  localparam logic [2:0]  CNT_FOUR      = 3'h4;

  // ----------------------------------------------------------------
  // controller state, gray coded
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ITL_IDLE   = 1'h0,
    ITL_ACTIVE = 1'h1
  } itl_state_type;

endpackage : itl_pkg

// file: verif/itl_engine_model.sv
// itl_engine_model: bus engine stand-in that ends each launched transaction
// assumes: launch_i is a one-cycle pulse on sys_clk_i
`timescale 1ns/1ns
`default_nettype none
module itl_engine_model #(
  parameter int HOLD = 12
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // launch in, end out
  input  wire logic launch_i,
  output var  logic txn_end_o
);
  int cnt_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q     <= 0;
      txn_end_o <= 1'b0;
    end else begin
      txn_end_o <= (cnt_q == 1);
      if (launch_i) begin
        cnt_q <= HOLD;
      end else if (cnt_q != 0) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule : itl_engine_model
`default_nettype wire

// file: verif/testbench.sv
// testbench: directed checks of the request register and launch logic
// assumes: itl_launch and itl_engine_model compiled before
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        sys_clk_i   = 1'b0;
  logic        nrst_i      = 1'b0;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [7:0]  reg_addr_i  = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        plm         = 1'b0;
  logic        awm         = 1'b0;
  logic        tbm         = 1'b0;
  logic        ce          = 1'b1;
  logic [15:0] rdata, v;
  logic        launch, active, rej, rnw, pf, ps, txn_end, tbo;
  logic [9:0]  taddr;
  logic [2:0]  cnt;
  logic [1:0]  loc;
  logic [3:0]  en;
  int          num_errors  = 0;
  int          checks      = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  itl_launch itl_launch_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata), .pointer_length_mode_i(plm),
    .alternate_write_mode_i(awm), .ten_bit_mode_i(tbm), .txn_end_i(txn_end),
    .launch_o(launch), .active_o(active), .request_rejected_fault_o(rej),
    .target_address_o(taddr), .ten_bit_o(tbo), .read_not_write_o(rnw),
    .send_pointer_byte_first_o(pf), .send_pointer_byte_second_o(ps),
    .data_byte_count_o(cnt), .data_location_select_o(loc), .data_byte_enable_o(en));
  itl_engine_model itl_engine_model_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .launch_i(launch), .txn_end_o(txn_end));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk_i);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    @(negedge sys_clk_i);
    reg_wr_i    = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge sys_clk_i);
    reg_rd_i   = 1'b1;
    reg_addr_i = a;
    @(negedge sys_clk_i);
    reg_rd_i   = 1'b0;
    d          = rdata;
  endtask : rd
  task automatic dec(input logic [9:0] ta, input logic r, f, s, input logic [2:0] c,
                     input logic [1:0] l, input logic [3:0] e);
    chk("target", {6'h00, ta}, {6'h00, taddr});
    chk("rnw", {15'h0000, r}, {15'h0000, rnw});
    chk("ptr first", {15'h0000, f}, {15'h0000, pf});
    chk("ptr second", {15'h0000, s}, {15'h0000, ps});
    chk("count", {13'h0000, c}, {13'h0000, cnt});
    chk("location", {14'h0000, l}, {14'h0000, loc});
    chk("enables", {12'h000, e}, {12'h000, en});
  endtask : dec
  task automatic go(input logic [15:0] d);
    wr(8'h8B, d);
    chk("launch", 16'h0001, {15'h0000, launch});
    chk("active", 16'h0001, {15'h0000, active});
  endtask : go
  task automatic wait_idle();
    for (int i = 0; i < 40 && active !== 1'b0; i++) @(negedge sys_clk_i);
    chk("idle", 16'h0000, {15'h0000, active});
  endtask : wait_idle
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic t_reset();
    rd(8'h8B, v);
    chk("reset value", 16'h2800, v);
    dec(10'h000, 1'b0, 1'b1, 1'b0, 3'h2, 2'h1, 4'h3);
    rd(8'h8C, v);
    chk("unmapped", 16'h0000, v);
    $display("reset test done");
  endtask : t_reset
  task automatic t_reject();
    tbm = 1'b1;
    go(16'hFDAB);
    dec(10'h2D5, 1'b1, 1'b0, 1'b1, 3'h4, 2'h3, 4'hF);
    chk("ten bit", 16'h0001, {15'h0000, tbo});
    wr(8'h8B, 16'h1234);
    chk("reject", 16'h0001, {15'h0000, rej});
    chk("no launch", 16'h0000, {15'h0000, launch});
    rd(8'h8B, v);
    chk("kept", 16'hFDAB, v);
    chk("one pulse", 16'h0000, {15'h0000, rej});
    wait_idle();
    $display("reject test done");
  endtask : t_reject
  task automatic t_modes();
    tbm = 1'b0;
    awm = 1'b1;
    plm = 1'b1;
    go(16'h4702);
    dec(10'h001, 1'b0, 1'b1, 1'b1, 3'h0, 2'h0, 4'h0);
    chk("ten bit", 16'h0000, {15'h0000, tbo});
    wait_idle();
    plm = 1'b0;
    go(16'h4807);
    dec(10'h003, 1'b1, 1'b1, 1'b0, 3'h3, 2'h1, 4'h3);
    rd(8'h8B, v);
    chk("readback", 16'h4807, v);
    wait_idle();
    $display("modes test done");
  endtask : t_modes
  task automatic t_freeze();
    ce = 1'b0;
    wr(8'h8B, 16'h0001);
    chk("frozen launch", 16'h0000, {15'h0000, launch});
    chk("frozen active", 16'h0000, {15'h0000, active});
    ce = 1'b1;
    rd(8'h8B, v);
    chk("frozen keep", 16'h4807, v);
    $display("freeze test done");
  endtask : t_freeze
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (8) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    t_reset();
    t_reject();
    t_modes();
    t_freeze();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
